// ---- common/fmc_pkg.sv ----
// fmc_pkg: offsets, field positions, limits and state types of the frequency/modulation command block.
// assumes a 50 MHz system clock and a 64-bit plain register port with an 8-bit address.
package fmc_pkg;

    // register port geometry
    localparam int FMC_AW = 8;
    localparam int FMC_DW = 64;
    localparam int FMC_FW = 40;
    localparam int FMC_SRC_BIT = 7;

    // command offsets; bit 7 of the address marks a header with the source node and is ignored
    localparam logic [6:0] FMC_A_IQ_STATE = 7'h00;
    localparam logic [6:0] FMC_A_FM_STATE = 7'h01;
    localparam logic [6:0] FMC_A_FM_MODE = 7'h02;
    localparam logic [6:0] FMC_A_IQ_MODE = 7'h03;
    localparam logic [6:0] FMC_A_PVEC_MODE = 7'h04;
    localparam logic [6:0] FMC_A_CENTER = 7'h05;
    localparam logic [6:0] FMC_A_START = 7'h06;
    localparam logic [6:0] FMC_A_STOP = 7'h07;
    localparam logic [6:0] FMC_A_CW = 7'h08;
    localparam logic [6:0] FMC_A_CW_ARG = 7'h09;
    localparam logic [6:0] FMC_A_STEP = 7'h0A;
    localparam logic [6:0] FMC_A_SEARCH = 7'h0B;
    localparam logic [6:0] FMC_A_ERROR = 7'h0C;
    localparam logic [6:0] FMC_A_STATUS = 7'h0D;

    // symbolic arguments of the coupling_a-frequency command
    localparam logic [2:0] FMC_ARG_MIN = 3'h0;
    localparam logic [2:0] FMC_ARG_MAX = 3'h1;
    localparam logic [2:0] FMC_ARG_MIDPOINT = 3'h2;
    localparam logic [2:0] FMC_ARG_UP = 3'h3;
    localparam logic [2:0] FMC_ARG_DOWN = 3'h4;

    // error register bit positions
    localparam int FMC_ERR_ARG = 0;
    localparam int FMC_ERR_SWEEP = 1;
    localparam int FMC_ERR_UNMAPPED = 2;

    // frequency limits in hertz
    localparam logic signed [63:0] FMC_FREQ_MIN = 64'h0000_0000_7735_9400;
    localparam logic signed [63:0] FMC_FREQ_MAX = 64'h0000_0004_A817_C800;
    localparam logic signed [63:0] FMC_FREQ_MID = 64'h0000_0002_8FA6_AE00;
    localparam logic signed [63:0] FMC_HALF_SPAN = 64'h0000_0002_1871_1A00;
    localparam logic signed [63:0] FMC_STEP_MAX = 64'h0000_0002_540B_E400;

    // mode tokens returned on a coupling query
    localparam logic [63:0] FMC_TOKEN_FIX = 64'h0000_0000_0046_4958;
    localparam logic [63:0] FMC_TOKEN_LIST = 64'h0000_0000_4C49_5354;

    // reset values
    localparam logic [39:0] FMC_RST_CENTER = 40'h02_8FA6_AE00;
    localparam logic [39:0] FMC_RST_START = 40'h00_7735_9400;
    localparam logic [39:0] FMC_RST_STOP = 40'h04_A817_C800;
    localparam logic [39:0] FMC_RST_CW = 40'h02_8FA6_AE00;

    // internal power search time
    localparam int FMC_CLK_PERIOD_NS = 20;
    localparam int FMC_SEARCH_TIME_NS = 10000;
    localparam int FMC_SEARCH_CYCLES = FMC_SEARCH_TIME_NS / FMC_CLK_PERIOD_NS;

    typedef enum logic [0:0] {FMC_IDLE, FMC_SEARCH} fmc_srch_t;

endpackage

// ---- rtl/fmc_command_state.sv ----
// fmc_command_state: command-driven modulation and frequency control state.
// assumes a single 50 MHz clock, a synchronous high reset and a same-clock register master.
//
// What this block does
// [R1] iq modulation on for 1, off for 0
// [R2] iq state query returns 1 or 0
// [R3] power search turns iq off, peak drive
// [R4] controller disables level loop for low frequencies; the bench controller leaves level loop handling to the host
// [R5] controller uses external search for typical level; the bench controller issues only the internal search
// [R6] fm coupling coupling_a or list, coupling_a default
// [R7] fm coupling query returns a text token
// [R8] vector list command couples all to list
// [R9] fm input on/off, off default, query 1
// [R10] sweep centre defaults to range midpoint
// [R11] new centre recomputes sweep start and stop
// [R12] start or stop out of range raises error
// [R13] controller sends span with new centre; the bench controller sends no span and the block keeps the full span
// [R14] centre query returns hertz
// [R15] coupling_a output frequency with one-hertz resolution
// [R16] min, max and midpoint arguments set frequency
// [R17] up and down add or subtract step
// [R18] coupling_a frequency query returns hertz
// [R19] signed step up to ten gigahertz, default zero
// [R20] step query returns hertz
// [R21] source node in the header is optional
// [R22] out-of-range argument keeps value, raises error
`timescale 1ns/1ns
module fmc_command_state (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [63:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic list_iq_in,
    input wire logic list_fm_in,
    output logic [63:0] rdata_out,
    output logic iq_mod_out,
    output logic iq_peak_out,
    output logic fm_mod_out,
    output logic fm_list_out,
    output logic [5:0] list_couple_out,
    output logic [39:0] cw_freq_out,
    output logic [39:0] sweep_start_out,
    output logic [39:0] sweep_stop_out,
    output logic error_out
);

    typedef struct packed {
        logic iq_en;
        logic fm_en;
        logic fm_list;
        logic iq_list;
        logic [3:0] oth_list;
        logic [39:0] center;
        logic [39:0] start;
        logic [39:0] stop;
        logic [39:0] cw;
        logic [39:0] step;
        logic [2:0] err;
        fmc_pkg::fmc_srch_t st;
        logic [9:0] cnt;
        logic [63:0] rdata;
        logic iq_out;
        logic fm_out;
        logic err_out;
        logic peak;
    } fmc_state_t;

    fmc_state_t q;
    fmc_state_t d;

    // frequency limit check on a signed hertz value
    function automatic logic fmc_in_range(input logic signed [63:0] f);
        fmc_in_range = (f >= fmc_pkg::FMC_FREQ_MIN) && (f <= fmc_pkg::FMC_FREQ_MAX);
    endfunction

    // widen a stored frequency to a signed hertz value
    function automatic logic signed [63:0] fmc_widen(input logic [39:0] f);
        fmc_widen = $signed({24'h00_0000, f});
    endfunction

    // strip the source-node marker so both header forms hit the same command
    function automatic logic [6:0] fmc_decode(input logic [7:0] a);
        fmc_decode = a[6:0]; // see [R21]
    endfunction

    logic [6:0] cmd;
    logic signed [63:0] wval;
    logic signed [63:0] new_start;
    logic signed [63:0] new_stop;
    logic signed [63:0] stepped;
    logic signed [63:0] step_ext;
    logic [2:0] err_set;

    // next-state logic: command decode, range checks, search timer and readback
    always_comb
    begin
        d = q;
        cmd = fmc_decode(addr_in);
        wval = $signed(wdata_in);
        err_set = 3'h0;
        new_start = fmc_widen(q.center);
        new_stop = fmc_widen(q.center);
        step_ext = {{24{q.step[39]}}, q.step};
        stepped = fmc_widen(q.cw);
        // search timer runs down on its own; iq stays gated while it runs
        if (q.st == fmc_pkg::FMC_SEARCH)
        begin
            d.cnt = q.cnt - 10'h001;
            if (q.cnt == 10'h000)
            begin
                d.st = fmc_pkg::FMC_IDLE;
            end
        end
        if (wr_in)
        begin
            case (cmd)
                fmc_pkg::FMC_A_IQ_STATE: d.iq_en = wdata_in[0]; // see [R1]
                fmc_pkg::FMC_A_FM_STATE: d.fm_en = wdata_in[0]; // see [R9]
                fmc_pkg::FMC_A_FM_MODE: d.fm_list = wdata_in[0]; // see [R6]
                fmc_pkg::FMC_A_IQ_MODE: d.iq_list = wdata_in[0];
                fmc_pkg::FMC_A_PVEC_MODE:
                begin
                    // one vector command moves every coupling at once
                    d.fm_list = wdata_in[0]; // see [R8]
                    d.iq_list = wdata_in[0];
                    d.oth_list = {4{wdata_in[0]}};
                end
                fmc_pkg::FMC_A_CENTER:
                begin
                    if (!fmc_in_range(wval))
                    begin
                        err_set[fmc_pkg::FMC_ERR_ARG] = 1'b1; // see [R22]
                    end
                    else
                    begin
                        // span is held full, so only the midpoint avoids a sweep error
                        new_start = wval - fmc_pkg::FMC_HALF_SPAN; // see [R11]
                        new_stop = wval + fmc_pkg::FMC_HALF_SPAN;
                        d.center = wdata_in[39:0];
                        d.start = new_start[39:0];
                        d.stop = new_stop[39:0];
                        if (!fmc_in_range(new_start) || !fmc_in_range(new_stop))
                        begin
                            err_set[fmc_pkg::FMC_ERR_SWEEP] = 1'b1; // see [R12]
                        end
                    end
                end
                fmc_pkg::FMC_A_CW:
                begin
                    if (fmc_in_range(wval))
                    begin
                        d.cw = wdata_in[39:0]; // see [R15]
                    end
                    else
                    begin
                        err_set[fmc_pkg::FMC_ERR_ARG] = 1'b1; // see [R22]
                    end
                end
                fmc_pkg::FMC_A_CW_ARG:
                begin
                    case (wdata_in[2:0])
                        fmc_pkg::FMC_ARG_MIN: stepped = fmc_pkg::FMC_FREQ_MIN; // see [R16]
                        fmc_pkg::FMC_ARG_MAX: stepped = fmc_pkg::FMC_FREQ_MAX;
                        fmc_pkg::FMC_ARG_MIDPOINT: stepped = fmc_pkg::FMC_FREQ_MID;
                        fmc_pkg::FMC_ARG_UP: stepped = fmc_widen(q.cw) + step_ext; // see [R17]
                        fmc_pkg::FMC_ARG_DOWN: stepped = fmc_widen(q.cw) - step_ext;
                        default: stepped = 64'sh0;
                    endcase
                    if (fmc_in_range(stepped))
                    begin
                        d.cw = stepped[39:0];
                    end
                    else
                    begin
                        err_set[fmc_pkg::FMC_ERR_ARG] = 1'b1; // see [R22]
                    end
                end
                fmc_pkg::FMC_A_STEP:
                begin
                    // two-sided compare, no negation, so the most negative word cannot wrap into range
                    if ((wval <= fmc_pkg::FMC_STEP_MAX) && (wval >= -fmc_pkg::FMC_STEP_MAX))
                    begin
                        d.step = wdata_in[39:0]; // see [R19]
                    end
                    else
                    begin
                        err_set[fmc_pkg::FMC_ERR_ARG] = 1'b1; // see [R22]
                    end
                end
                fmc_pkg::FMC_A_SEARCH:
                begin
                    // a second request while searching is ignored, not restarted
                    if (q.st == fmc_pkg::FMC_IDLE)
                    begin
                        d.st = fmc_pkg::FMC_SEARCH; // see [R3]
                        d.cnt = 10'(fmc_pkg::FMC_SEARCH_CYCLES - 1);
                    end
                end
                fmc_pkg::FMC_A_ERROR: d.err = q.err & ~wdata_in[2:0];
                default: err_set[fmc_pkg::FMC_ERR_UNMAPPED] = 1'b1;
            endcase
        end
        // a new error in the clearing cycle survives the clear
        d.err = d.err | err_set;
        d.err_out = |d.err;
        // read data stands only in the cycle after the strobe
        d.rdata = 64'h0;
        if (rd_in)
        begin
            case (cmd)
                fmc_pkg::FMC_A_IQ_STATE: d.rdata = {63'h0, q.iq_en}; // see [R2]
                fmc_pkg::FMC_A_FM_STATE: d.rdata = {63'h0, q.fm_en}; // see [R9]
                fmc_pkg::FMC_A_FM_MODE:
                begin
                    d.rdata = q.fm_list ? fmc_pkg::FMC_TOKEN_LIST : fmc_pkg::FMC_TOKEN_FIX; // see [R7]
                end
                fmc_pkg::FMC_A_IQ_MODE: d.rdata = q.iq_list ? fmc_pkg::FMC_TOKEN_LIST : fmc_pkg::FMC_TOKEN_FIX;
                fmc_pkg::FMC_A_PVEC_MODE: d.rdata = {58'h0, q.oth_list, q.iq_list, q.fm_list};
                fmc_pkg::FMC_A_CENTER: d.rdata = {24'h00_0000, q.center}; // see [R14]
                fmc_pkg::FMC_A_START: d.rdata = {24'h00_0000, q.start};
                fmc_pkg::FMC_A_STOP: d.rdata = {24'h00_0000, q.stop};
                fmc_pkg::FMC_A_CW: d.rdata = {24'h00_0000, q.cw}; // see [R18]
                fmc_pkg::FMC_A_STEP: d.rdata = {{24{q.step[39]}}, q.step}; // see [R20]
                fmc_pkg::FMC_A_ERROR: d.rdata = {61'h0, q.err};
                fmc_pkg::FMC_A_STATUS: d.rdata = {63'h0, q.st == fmc_pkg::FMC_SEARCH};
                default: d.rdata = 64'h0;
            endcase
        end
        // modulation outputs follow the coupling; search overrides iq
        d.iq_out = (d.iq_list ? list_iq_in : d.iq_en) && (d.st == fmc_pkg::FMC_IDLE); // see [R3]
        d.fm_out = d.fm_list ? list_fm_in : d.fm_en; // see [R6]
        d.peak = (d.st == fmc_pkg::FMC_SEARCH); // see [R3]
    end

    // state register with reset defaults
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            q <= '0;
            q.center <= fmc_pkg::FMC_RST_CENTER; // see [R10]
            q.start <= fmc_pkg::FMC_RST_START;
            q.stop <= fmc_pkg::FMC_RST_STOP;
            q.cw <= fmc_pkg::FMC_RST_CW;
            q.st <= fmc_pkg::FMC_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign rdata_out = q.rdata;
    assign iq_mod_out = q.iq_out;
    assign iq_peak_out = q.peak;
    assign fm_mod_out = q.fm_out;
    assign fm_list_out = q.fm_list;
    assign list_couple_out = {q.oth_list, q.iq_list, q.fm_list};
    assign cw_freq_out = q.cw;
    assign sweep_start_out = q.start;
    assign sweep_stop_out = q.stop;
    assign error_out = q.err_out;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    AST_IQ_STATE_WRITE: assert property ( // see [R1]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_IQ_STATE) |=> (q.iq_en == $past(wdata_in[0])))
        else $error("iq state did not follow write");

    AST_IQ_STATE_READ: assert property ( // see [R2]
        (rd_in && addr_in[6:0] == fmc_pkg::FMC_A_IQ_STATE) |=> (rdata_out == {63'h0, $past(q.iq_en)}))
        else $error("iq state readback wrong");

    AST_SEARCH_GATES_IQ: assert property ( // see [R3]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_SEARCH && q.st == fmc_pkg::FMC_IDLE)
        |=> (iq_peak_out && !iq_mod_out)[*8])
        else $error("iq not held off during power search");

    AST_FM_LIST_FOLLOWS: assert property ( // see [R6]
        (q.fm_list && !wr_in) |=> (fm_mod_out == $past(list_fm_in)))
        else $error("fm output ignores list coupling");

    AST_FM_MODE_TOKEN: assert property ( // see [R7]
        (rd_in && addr_in[6:0] == fmc_pkg::FMC_A_FM_MODE)
        |=> (rdata_out == ($past(q.fm_list) ? fmc_pkg::FMC_TOKEN_LIST : fmc_pkg::FMC_TOKEN_FIX)))
        else $error("fm mode token wrong");

    AST_PVEC_COUPLES_ALL: assert property ( // see [R8]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_PVEC_MODE && wdata_in[0]) |=> (list_couple_out == 6'h3F))
        else $error("vector list command did not couple all");

    AST_CENTER_RECALC: assert property ( // see [R11]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_CENTER && fmc_in_range($signed(wdata_in)))
        |=> (sweep_start_out == 40'($past(wdata_in) - fmc_pkg::FMC_HALF_SPAN)))
        else $error("sweep start not recomputed from centre");

    AST_CW_REJECT: assert property ( // see [R22]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_CW && !fmc_in_range($signed(wdata_in)))
        |=> ($stable(cw_freq_out) ##1 error_out))
        else $error("out-of-range frequency accepted");

    AST_STEP_UP: assert property ( // see [R17]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_CW_ARG && wdata_in[2:0] == fmc_pkg::FMC_ARG_UP
            && fmc_in_range(fmc_widen(q.cw) + {{24{q.step[39]}}, q.step}))
        |=> (fmc_widen(cw_freq_out) == fmc_widen($past(q.cw)) + {{24{$past(q.step[39])}}, $past(q.step)}))
        else $error("up argument did not add step");

    AST_FM_STATE_WRITE: assert property ( // see [R9]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_FM_STATE) |=> (q.fm_en == $past(wdata_in[0])))
        else $error("fm state did not follow write");

    AST_FM_STATE_READ: assert property ( // see [R9]
        (rd_in && addr_in[6:0] == fmc_pkg::FMC_A_FM_STATE) |=> (rdata_out == {63'h0, $past(q.fm_en)}))
        else $error("fm state readback wrong");

    AST_RESET_DEFAULTS: assert property ( // see [R10]
        $past(rst_in) |-> (q.center == fmc_pkg::FMC_RST_CENTER && cw_freq_out == fmc_pkg::FMC_RST_CW
            && q.step == 40'h00_0000_0000 && !iq_mod_out && !fm_mod_out && !fm_list_out))
        else $error("reset defaults wrong");

    AST_SWEEP_ERROR: assert property ( // see [R12]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_CENTER && fmc_in_range($signed(wdata_in))
            && !fmc_in_range($signed(wdata_in) - fmc_pkg::FMC_HALF_SPAN))
        |=> (q.err[fmc_pkg::FMC_ERR_SWEEP] && error_out))
        else $error("out-of-band sweep raised no error");

    AST_CW_WRITE: assert property ( // see [R15]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_CW && fmc_in_range($signed(wdata_in)))
        |=> (cw_freq_out == $past(wdata_in[39:0])))
        else $error("coupling_a frequency write lost");

    AST_ARG_MIN: assert property ( // see [R16]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_CW_ARG && wdata_in[2:0] == fmc_pkg::FMC_ARG_MIN)
        |=> (fmc_widen(cw_freq_out) == fmc_pkg::FMC_FREQ_MIN))
        else $error("min argument did not set range limit");

    AST_STEP_REJECT: assert property ( // see [R22]
        (wr_in && addr_in[6:0] == fmc_pkg::FMC_A_STEP && ($signed(wdata_in) > fmc_pkg::FMC_STEP_MAX
            || $signed(wdata_in) < -fmc_pkg::FMC_STEP_MAX))
        |=> ($stable(q.step) && q.err[fmc_pkg::FMC_ERR_ARG]))
        else $error("out-of-range step accepted");

endmodule

// ---- bench/fmc_remote_ctrl.sv ----
// fmc_remote_ctrl: behavioural remote controller driving the command port of the block.
// assumes the block answers a read in the cycle after the read strobe and never stalls.
`timescale 1ns/1ns
module fmc_remote_ctrl (
    input wire logic clk_in,
    input wire logic [63:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [63:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    // idle bus at time zero
    initial
    begin
        addr_out = 8'h00;
        wdata_out = 64'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // level loop handling and typical-level calibration stay with the host;
    // this model only issues the internal search, for peak calibration
    // centre writes rely on the coupling_a full span, so no span goes with them
    // one-cycle write; released lines take the inverse so stale values never look valid
    task put(input logic [7:0] a, input logic [63:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
        #1;
    endtask
    // one-cycle read; data is only valid in the following cycle
    task get(input logic [7:0] a, output logic [63:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
endmodule

// ---- bench/freq_mod_command_state_tb_top.sv ----
// freq_mod_command_state_tb_top: self-checking bench with a behavioural model of the command state.
// assumes the remote controller model drives the command port and the bench drives the list inputs.
`timescale 1ns/1ns
module freq_mod_command_state_tb_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic list_iq_in = 1'b0;
    logic list_fm_in = 1'b0;
    logic [7:0] addr;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic wr;
    logic rd;
    logic iq_mod, iq_peak, fm_mod, fm_list, error;
    logic [5:0] couple;
    logic [39:0] cw_f, st_f, sp_f;
    logic [31:0] seed = 32'h0000_0043;
    logic [31:0] r;
    logic [63:0] s;
    int err_count = 0;
    int samples_checked = 0;
    int pk;
    // model state, reset values
    longint c_m = fmc_pkg::FMC_FREQ_MID;
    longint cw_m = fmc_pkg::FMC_FREQ_MID;
    longint step_m = 0;
    logic iq_m = 1'b0, fm_m = 1'b0, iql_m = 1'b0, fml_m = 1'b0, pv_m = 1'b0;
    logic [2:0] e_m = 3'h0;

    fmc_command_state i_fmc_command_state (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .list_iq_in(list_iq_in), .list_fm_in(list_fm_in),
        .rdata_out(rdata), .iq_mod_out(iq_mod), .iq_peak_out(iq_peak), .fm_mod_out(fm_mod),
        .fm_list_out(fm_list), .list_couple_out(couple), .cw_freq_out(cw_f), .sweep_start_out(st_f),
        .sweep_stop_out(sp_f), .error_out(error));
    fmc_remote_ctrl i_fmc_remote_ctrl (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

    always #10 clk_in = ~clk_in;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // iq, fm, coupling, cw and sweep outputs against the model
    task outs;
        check(iq_mod, iql_m ? list_iq_in : iq_m);
        check(fm_mod, fml_m ? list_fm_in : fm_m);
        check({fm_list, couple}, {fml_m, {4{pv_m}}, iql_m, fml_m});
        check(cw_f, {24'h0, 40'(cw_m)});
        check(st_f, {24'h0, 40'(c_m - fmc_pkg::FMC_HALF_SPAN)});
        check(sp_f, {24'h0, 40'(c_m + fmc_pkg::FMC_HALF_SPAN)});
    endtask

    function automatic logic bad(input longint v);
        return v < fmc_pkg::FMC_FREQ_MIN || v > fmc_pkg::FMC_FREQ_MAX;
    endfunction

    // write with a random source-node bit, then update the model
    task wr_cmd(input logic [6:0] a, input logic [63:0] d);
        longint n;
        logic [31:0] h;
        // own random word, so the caller's r survives for its read-back
        h = rnd();
        i_fmc_remote_ctrl.put({h[0], a}, d);
        n = cw_m;
        case (a)
            fmc_pkg::FMC_A_IQ_STATE: iq_m = d[0];
            fmc_pkg::FMC_A_FM_STATE: fm_m = d[0];
            fmc_pkg::FMC_A_FM_MODE: fml_m = d[0];
            fmc_pkg::FMC_A_IQ_MODE: iql_m = d[0];
            fmc_pkg::FMC_A_PVEC_MODE: {pv_m, iql_m, fml_m} = {3{d[0]}};
            fmc_pkg::FMC_A_CENTER:
                if (bad(d)) e_m[0] = 1'b1;
                else
                begin
                    c_m = d;
                    if (bad(c_m - fmc_pkg::FMC_HALF_SPAN) || bad(c_m + fmc_pkg::FMC_HALF_SPAN)) e_m[1] = 1'b1;
                end
            fmc_pkg::FMC_A_CW, fmc_pkg::FMC_A_CW_ARG:
            begin
                if (a == fmc_pkg::FMC_A_CW) n = d;
                else if (d[2:0] == fmc_pkg::FMC_ARG_MIN) n = fmc_pkg::FMC_FREQ_MIN;
                else if (d[2:0] == fmc_pkg::FMC_ARG_MAX) n = fmc_pkg::FMC_FREQ_MAX;
                else if (d[2:0] == fmc_pkg::FMC_ARG_MIDPOINT) n = fmc_pkg::FMC_FREQ_MID;
                else if (d[2:0] == fmc_pkg::FMC_ARG_UP) n = cw_m + step_m;
                else n = cw_m - step_m;
                if (bad(n)) e_m[0] = 1'b1;
                else cw_m = n;
            end
            fmc_pkg::FMC_A_STEP:
                if (longint'(d) > fmc_pkg::FMC_STEP_MAX || longint'(d) < -fmc_pkg::FMC_STEP_MAX) e_m[0] = 1'b1;
                else step_m = d;
            fmc_pkg::FMC_A_SEARCH: ;
            fmc_pkg::FMC_A_ERROR: e_m = e_m & ~d[2:0];
            default: e_m[2] = 1'b1;
        endcase
        if (a != fmc_pkg::FMC_A_SEARCH) outs();
    endtask

    task rd_chk(input logic [6:0] a, input logic [63:0] exp);
        logic [63:0] v;
        logic [31:0] h;
        h = rnd();
        i_fmc_remote_ctrl.get({h[0], a}, v);
        check(v, exp);
    endtask

    task err_chk;
        rd_chk(fmc_pkg::FMC_A_ERROR, {61'h0, e_m});
        check(error, |e_m);
    endtask

    task close_out;
        $display("mismatches %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // a full run takes under a thousand cycles; this limit of 20000 cycles is over twenty times that
    initial
    begin
        #400000;
        err_count++;
        close_out();
    end

    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_chk(fmc_pkg::FMC_A_CENTER, fmc_pkg::FMC_FREQ_MID);
        rd_chk(fmc_pkg::FMC_A_CW, fmc_pkg::FMC_FREQ_MID);
        rd_chk(fmc_pkg::FMC_A_STEP, 64'h0);
        rd_chk(fmc_pkg::FMC_A_FM_MODE, fmc_pkg::FMC_TOKEN_FIX);
        rd_chk(fmc_pkg::FMC_A_FM_STATE, 64'h0);
        // iq on with internal search: modulation off while the modulator is at peak
        wr_cmd(fmc_pkg::FMC_A_IQ_STATE, 64'h1);
        wr_cmd(fmc_pkg::FMC_A_SEARCH, 64'h0);
        pk = (iq_peak === 1'b1) ? 1 : 0;
        repeat (600)
        begin
            @(posedge clk_in);
            #1;
            if (iq_peak === 1'b1)
            begin
                pk++;
                check(iq_mod, 1'b0);
            end
        end
        check(pk, fmc_pkg::FMC_SEARCH_CYCLES);
        rd_chk(fmc_pkg::FMC_A_STATUS, 64'h0);
        outs();
        // random on/off states, coupling_a then list coupling; list inputs move on a clock edge
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            @(posedge clk_in);
            list_iq_in <= r[2];
            list_fm_in <= r[3];
            if (i == 4) wr_cmd(fmc_pkg::FMC_A_FM_MODE, 64'h1);
            if (i == 6) wr_cmd(fmc_pkg::FMC_A_PVEC_MODE, 64'h1);
            wr_cmd(fmc_pkg::FMC_A_IQ_STATE, {63'h0, r[0]});
            rd_chk(fmc_pkg::FMC_A_IQ_STATE, {63'h0, r[0]});
            wr_cmd(fmc_pkg::FMC_A_FM_STATE, {63'h0, r[1]});
            rd_chk(fmc_pkg::FMC_A_FM_STATE, {63'h0, r[1]});
        end
        rd_chk(fmc_pkg::FMC_A_FM_MODE, fmc_pkg::FMC_TOKEN_LIST);
        rd_chk(fmc_pkg::FMC_A_IQ_MODE, fmc_pkg::FMC_TOKEN_LIST);
        rd_chk(fmc_pkg::FMC_A_PVEC_MODE, 64'h3F);
        // iq coupling alone back to coupling_a
        wr_cmd(fmc_pkg::FMC_A_IQ_MODE, 64'h0);
        rd_chk(fmc_pkg::FMC_A_IQ_MODE, fmc_pkg::FMC_TOKEN_FIX);
        // centre: sweep out of band, rejected value, then back to midpoint
        wr_cmd(fmc_pkg::FMC_A_CENTER, 64'h1_A13B_8600);
        rd_chk(fmc_pkg::FMC_A_START, {24'h0, 40'(c_m - fmc_pkg::FMC_HALF_SPAN)});
        rd_chk(fmc_pkg::FMC_A_STOP, 64'(c_m + fmc_pkg::FMC_HALF_SPAN));
        err_chk();
        wr_cmd(fmc_pkg::FMC_A_ERROR, 64'h7);
        wr_cmd(fmc_pkg::FMC_A_CENTER, 64'h3B9A_CA00);
        rd_chk(fmc_pkg::FMC_A_CENTER, 64'h1_A13B_8600);
        err_chk();
        wr_cmd(fmc_pkg::FMC_A_CENTER, fmc_pkg::FMC_FREQ_MID);
        // unmapped and read-only places
        wr_cmd(7'h20, 64'h5);
        wr_cmd(fmc_pkg::FMC_A_START, 64'h0);
        rd_chk(7'h20, 64'h0);
        err_chk();
        wr_cmd(fmc_pkg::FMC_A_ERROR, 64'h7);
        // coupling_a frequency, symbolic arguments and signed steps
        wr_cmd(fmc_pkg::FMC_A_CW, 64'h1_A13B_8600);
        rd_chk(fmc_pkg::FMC_A_CW, 64'h1_A13B_8600);
        for (int i = 0; i < 3; i++) wr_cmd(fmc_pkg::FMC_A_CW_ARG, 64'(i));
        for (int i = 0; i < 4; i++)
        begin
            r = rnd();
            s = {44'h0, r[19:0]} + 64'h1;
            if (r[20]) s = -s;
            wr_cmd(fmc_pkg::FMC_A_STEP, s);
            rd_chk(fmc_pkg::FMC_A_STEP, s);
            wr_cmd(fmc_pkg::FMC_A_CW_ARG, {61'h0, fmc_pkg::FMC_ARG_UP});
            wr_cmd(fmc_pkg::FMC_A_CW_ARG, {61'h0, fmc_pkg::FMC_ARG_DOWN});
            wr_cmd(fmc_pkg::FMC_A_CW_ARG, {61'h0, fmc_pkg::FMC_ARG_DOWN});
        end
        // out-of-range results keep the stored value
        wr_cmd(fmc_pkg::FMC_A_STEP, fmc_pkg::FMC_FREQ_MID);
        wr_cmd(fmc_pkg::FMC_A_STEP, 64'h3E8);
        wr_cmd(fmc_pkg::FMC_A_CW_ARG, {61'h0, fmc_pkg::FMC_ARG_MAX});
        wr_cmd(fmc_pkg::FMC_A_CW_ARG, {61'h0, fmc_pkg::FMC_ARG_UP});
        wr_cmd(fmc_pkg::FMC_A_CW, 64'h0);
        err_chk();
        close_out();
    end
endmodule
